// file: include/irae_pkg.sv
package irae_pkg;
    localparam logic [7:0] OFS_CSR_DATA = 8'h10;
    localparam logic [7:0] OFS_PTR_WORD = 8'h12;
    localparam logic [7:0] OFS_PTR_DWORD = 8'h14;
    localparam logic [7:0] OFS_BUS_CFG_WORD = 8'h16;
    localparam logic [7:0] OFS_BUS_CFG_DWORD = 8'h1C;
    localparam logic [7:0] CFG_PM_BSE = 8'h46;
    localparam logic [7:0] CFG_PM_DATA = 8'h47;
    localparam logic [7:0] IDX_MAIN = 8'h00;
    localparam logic [7:0] IDX_MASK = 8'h03;
    localparam logic [7:0] IDX_BUS_TMO = 8'h64;
    localparam logic [7:0] IDX_MISS_CNT = 8'h70;
    localparam logic [7:0] IDX_PM_ALIAS_LO = 8'h25;
    localparam logic [7:0] IDX_PM_ALIAS_HI = 8'h2C;
    localparam int BIT_ERR = 15;
    localparam int BIT_COL_FAIL = 13;
    localparam int BIT_MISS = 12;
    localparam int BIT_BUS_TMO = 11;
    localparam int BIT_INT_PEND = 7;
    localparam int BIT_INT_ENA = 6;
    localparam int BIT_STOP = 2;
    localparam int BIT_STRT = 1;
    localparam int BIT_INIT = 0;
    localparam int BIT_MISS_MASK = 12;
    localparam int BIT_BUS_TMO_MASK = 11;
    localparam int FLAG_COL_FAIL = 0;
    localparam int FLAG_MISS = 1;
    localparam int FLAG_BUS_TMO = 2;
    localparam logic [7:0] PM_BSE_VALUE = 8'h00;
    localparam logic [7:0] PM_DATA_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] BUS_TMO_RESET = 16'h0600;
    localparam logic [15:0] MISS_CNT_RESET = 16'h0000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BUS_TMO_UNIT_NS = 100;
    localparam int BUS_TMO_UNIT_CYCLES = (BUS_TMO_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_TEST_BIT_TIMES = 20;
endpackage

// file: hw/irae_sync.sv
`timescale 1ns/10ps
`default_nettype none
module irae_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // Two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// file: hw/irae_bus_timer.sv
`timescale 1ns/10ps
`default_nettype none
module irae_bus_timer #(
    parameter int UNIT_CYCLES = irae_pkg::BUS_TMO_UNIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic gnt_i,
    input wire logic [15:0] limit_i,
    output logic timeout_o
);
    logic [15:0] div;
    logic [15:0] units;
    logic fired;
    logic waiting;
    logic tick;

    assign waiting = req_i && !gnt_i;
    assign tick = (div == 16'(UNIT_CYCLES - 1));

    // Time-unit divider runs only while waiting for grant
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div <= '0;
        end else if (!waiting || tick) begin
            div <= '0;
        end else begin
            div <= div + 16'h0001;
        end
    end

    // Unit count and one pulse per unanswered request
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            units <= '0;
            fired <= 1'b0;
            timeout_o <= 1'b0;
        end else begin
            timeout_o <= 1'b0;
            if (!waiting) begin
                units <= '0;
                fired <= 1'b0;
            end else if (tick && !fired) begin
                units <= units + 16'h0001;
                if (units + 16'h0001 >= limit_i) begin
                    fired <= 1'b1;
                    timeout_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/irae_top.sv
`timescale 1ns/10ps
`default_nettype none
module irae_top #(
    parameter int COL_BITS = irae_pkg::COL_TEST_BIT_TIMES
) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic SW_RESET_I,
    input wire logic DOUBLEWORD_IO_MODE_I,
    input wire logic IO_RD_I,
    input wire logic IO_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    output logic [31:0] RDATA_O,
    output logic ACK_O,
    input wire logic EE_LOAD_I,
    input wire logic [7:0] EE_PM_DATA_I,
    input wire logic HALF_DUPLEX_I,
    input wire logic MII_SEL_I,
    input wire logic PHY_10BT_I,
    input wire logic TX_END_I,
    input wire logic BIT_TICK_I,
    input wire logic COL_PIN_I,
    input wire logic FRAME_MISSED_I,
    input wire logic BUS_REQ_I,
    input wire logic GNT_N_PIN_I,
    output logic REQ_N_O,
    output logic INT_N_O,
    output logic STOP_O
);
    logic [7:0] register_index_pointer;
    logic [7:0] pm_data_byte;
    logic [15:0] interrupt_mask_register;
    logic [15:0] bus_timeout_register;
    logic [15:0] missed_frame_counter;
    logic [2:0] err_flags;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic master_interrupt_enable;
    logic stop;
    logic sw_clear;
    logic csr_wr;
    logic bus_cfg_wr;
    logic ptr_wr;
    logic main_wr;
    logic error_summary;
    logic interrupt_pending_summary;
    logic col_sync;
    logic gnt_n_sync;
    logic bus_timeout;
    logic col_armed;
    logic [4:0] col_left;
    logic col_test_en;
    logic [31:0] next_rdata;

    function automatic logic is_ptr(input logic [7:0] a, input logic dw);
        is_ptr = dw ? (a == irae_pkg::OFS_PTR_DWORD) : (a == irae_pkg::OFS_PTR_WORD);
    endfunction

    function automatic logic is_bus_cfg(input logic [7:0] a, input logic dw);
        is_bus_cfg = dw ? (a == irae_pkg::OFS_BUS_CFG_DWORD) : (a == irae_pkg::OFS_BUS_CFG_WORD);
    endfunction

    irae_sync #(
        .WIDTH(2)
    ) irae_sync_inst (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .async_i({COL_PIN_I, GNT_N_PIN_I}),
        .sync_o({col_sync, gnt_n_sync})
    );

    irae_bus_timer #(
        .UNIT_CYCLES(irae_pkg::BUS_TMO_UNIT_CYCLES)
    ) irae_bus_timer_inst (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .req_i(BUS_REQ_I && !stop),
        .gnt_i(!gnt_n_sync),
        .limit_i(bus_timeout_register),
        .timeout_o(bus_timeout)
    );

    assign sw_clear = SW_RESET_I;
    assign ptr_wr = IO_WR_I && is_ptr(ADDR_I, DOUBLEWORD_IO_MODE_I);
    assign csr_wr = IO_WR_I && (ADDR_I == irae_pkg::OFS_CSR_DATA);
    assign bus_cfg_wr = IO_WR_I && is_bus_cfg(ADDR_I, DOUBLEWORD_IO_MODE_I);
    assign main_wr = csr_wr && (register_index_pointer == irae_pkg::IDX_MAIN);
    assign REQ_N_O = !(BUS_REQ_I && !stop);
    assign STOP_O = stop;

    // Pointer, untouched by stop
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            register_index_pointer <= irae_pkg::PTR_RESET;
        end else if (sw_clear) begin
            register_index_pointer <= irae_pkg::PTR_RESET;
        end else if (ptr_wr) begin
            register_index_pointer <= WDATA_I[7:0];
        end
    end

    // Power-management data byte from EEPROM
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pm_data_byte <= irae_pkg::PM_DATA_RESET;
        end else if (EE_LOAD_I) begin
            pm_data_byte <= EE_PM_DATA_I;
        end
    end

    // Stop control and master interrupt enable
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            stop <= 1'b1;
            master_interrupt_enable <= 1'b0;
        end else if (sw_clear) begin
            stop <= 1'b1;
            master_interrupt_enable <= 1'b0;
        end else if (main_wr) begin
            if (WDATA_I[irae_pkg::BIT_STOP]) begin
                stop <= 1'b1;
                master_interrupt_enable <= 1'b0;
            end else begin
                if (WDATA_I[irae_pkg::BIT_STRT] || WDATA_I[irae_pkg::BIT_INIT]) begin
                    stop <= 1'b0;
                end
                master_interrupt_enable <= WDATA_I[irae_pkg::BIT_INT_ENA];
            end
        end
    end

    // Interrupt mask and bus timeout registers
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            interrupt_mask_register <= irae_pkg::MASK_RESET;
            bus_timeout_register <= irae_pkg::BUS_TMO_RESET;
        end else if (sw_clear) begin
            interrupt_mask_register <= irae_pkg::MASK_RESET;
            bus_timeout_register <= irae_pkg::BUS_TMO_RESET;
        end else if (csr_wr) begin
            if (register_index_pointer == irae_pkg::IDX_MASK) begin
                interrupt_mask_register <= WDATA_I[15:0];
            end
            if (register_index_pointer == irae_pkg::IDX_BUS_TMO) begin
                bus_timeout_register <= WDATA_I[15:0];
            end
        end
    end

    // Collision test window after each transmission in half duplex, unless MII is selected without 10BT
    assign col_test_en = HALF_DUPLEX_I && (!MII_SEL_I || PHY_10BT_I);

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            col_armed <= 1'b0;
            col_left <= '0;
        end else if (TX_END_I && col_test_en) begin
            col_armed <= 1'b1;
            col_left <= 5'(COL_BITS);
        end else if (col_armed) begin
            if (col_sync || !col_test_en) begin
                col_armed <= 1'b0;
            end else if (BIT_TICK_I) begin
                col_left <= col_left - 5'h01;
                if (col_left == 5'h01) begin
                    col_armed <= 1'b0;
                end
            end
        end
    end

    assign flag_set[irae_pkg::FLAG_COL_FAIL] = col_armed && !col_sync && col_test_en
        && BIT_TICK_I && (col_left == 5'h01);
    assign flag_set[irae_pkg::FLAG_MISS] = FRAME_MISSED_I;
    assign flag_set[irae_pkg::FLAG_BUS_TMO] = bus_timeout;
    assign flag_clr[irae_pkg::FLAG_COL_FAIL] = main_wr && WDATA_I[irae_pkg::BIT_COL_FAIL];
    assign flag_clr[irae_pkg::FLAG_MISS] = main_wr && WDATA_I[irae_pkg::BIT_MISS];
    assign flag_clr[irae_pkg::FLAG_BUS_TMO] = main_wr && WDATA_I[irae_pkg::BIT_BUS_TMO];

    // Error flags: set beats host clear, reset and stop clear everything
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_flag
            always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
                if (!RSTN_I) begin
                    err_flags[g] <= 1'b0;
                end else if (sw_clear || stop) begin
                    err_flags[g] <= 1'b0;
                end else if (flag_set[g]) begin
                    err_flags[g] <= 1'b1;
                end else if (flag_clr[g]) begin
                    err_flags[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Missed-frame counter
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            missed_frame_counter <= irae_pkg::MISS_CNT_RESET;
        end else if (sw_clear) begin
            missed_frame_counter <= irae_pkg::MISS_CNT_RESET;
        end else if (FRAME_MISSED_I) begin
            missed_frame_counter <= missed_frame_counter + 16'h0001;
        end else if (csr_wr && register_index_pointer == irae_pkg::IDX_MISS_CNT) begin
            missed_frame_counter <= WDATA_I[15:0];
        end
    end

    assign error_summary = |err_flags;
    assign interrupt_pending_summary =
        (err_flags[irae_pkg::FLAG_MISS] && !interrupt_mask_register[irae_pkg::BIT_MISS_MASK])
        || (err_flags[irae_pkg::FLAG_BUS_TMO] && !interrupt_mask_register[irae_pkg::BIT_BUS_TMO_MASK]);
    assign INT_N_O = !(master_interrupt_enable && interrupt_pending_summary);

    // Read data selection
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (CFG_RD_I) begin
            if (ADDR_I == irae_pkg::CFG_PM_BSE) begin
                next_rdata[7:0] = irae_pkg::PM_BSE_VALUE;
            end else if (ADDR_I == irae_pkg::CFG_PM_DATA) begin
                next_rdata[7:0] = pm_data_byte;
            end
        end else if (IO_RD_I) begin
            if (is_ptr(ADDR_I, DOUBLEWORD_IO_MODE_I)) begin
                next_rdata[7:0] = register_index_pointer;
            end else if (ADDR_I == irae_pkg::OFS_CSR_DATA) begin
                unique case (register_index_pointer)
                    irae_pkg::IDX_MAIN: begin
                        next_rdata[irae_pkg::BIT_ERR] = error_summary;
                        next_rdata[irae_pkg::BIT_COL_FAIL] = err_flags[irae_pkg::FLAG_COL_FAIL];
                        next_rdata[irae_pkg::BIT_MISS] = err_flags[irae_pkg::FLAG_MISS];
                        next_rdata[irae_pkg::BIT_BUS_TMO] = err_flags[irae_pkg::FLAG_BUS_TMO];
                        next_rdata[irae_pkg::BIT_INT_PEND] = interrupt_pending_summary;
                        next_rdata[irae_pkg::BIT_INT_ENA] = master_interrupt_enable;
                        next_rdata[irae_pkg::BIT_STOP] = stop;
                    end
                    irae_pkg::IDX_MASK: begin
                        next_rdata[15:0] = interrupt_mask_register;
                    end
                    irae_pkg::IDX_BUS_TMO: begin
                        next_rdata[15:0] = bus_timeout_register;
                    end
                    irae_pkg::IDX_MISS_CNT: begin
                        next_rdata[15:0] = missed_frame_counter;
                    end
                    default: begin
                        next_rdata = 32'h0000_0000;
                    end
                endcase
            end else if (is_bus_cfg(ADDR_I, DOUBLEWORD_IO_MODE_I)) begin
                if (register_index_pointer >= irae_pkg::IDX_PM_ALIAS_LO
                    && register_index_pointer <= irae_pkg::IDX_PM_ALIAS_HI) begin
                    next_rdata[7:0] = pm_data_byte;
                end
            end
        end
    end

    // Registered read data and one-cycle acknowledge
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 32'h0000_0000;
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= IO_RD_I || IO_WR_I || CFG_RD_I;
            if (IO_RD_I || CFG_RD_I) begin
                RDATA_O <= next_rdata;
            end
        end
    end

    // Writes through the bus config port reach no writable register here
    logic unused_bus_cfg_wr;
    assign unused_bus_cfg_wr = bus_cfg_wr;
endmodule
`default_nettype wire

// file: test/irae_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module irae_asserts (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic SW_RESET_I,
    input wire logic DOUBLEWORD_IO_MODE_I,
    input wire logic IO_RD_I,
    input wire logic IO_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic [31:0] RDATA_O,
    input wire logic ACK_O,
    input wire logic FRAME_MISSED_I,
    input wire logic BUS_REQ_I,
    input wire logic REQ_N_O,
    input wire logic INT_N_O,
    input wire logic STOP_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RSTN_I);
    logic strobe;
    assign strobe = IO_RD_I | IO_WR_I | CFG_RD_I;
    sequence ptr_wr_rd;
        IO_WR_I && !DOUBLEWORD_IO_MODE_I && ADDR_I == 8'h12 && !SW_RESET_I
        ##1 IO_RD_I && !DOUBLEWORD_IO_MODE_I && ADDR_I == 8'h12 && !SW_RESET_I;
    endsequence
    a_ack_follows_req: assert property (strobe |=> ACK_O)
        else $error("ack missing after request");
    a_ack_has_cause: assert property (ACK_O |-> $past(strobe))
        else $error("ack without request");
    a_int_off_stop: assert property (STOP_O |-> INT_N_O)
        else $error("interrupt active while stopped");
    a_req_gated_stop: assert property (REQ_N_O == !(BUS_REQ_I && !STOP_O))
        else $error("bus request output wrong");
    a_sw_reset_clears: assert property (SW_RESET_I |=> STOP_O && INT_N_O)
        else $error("software reset did not stop");
    a_cfg_bse_zero: assert property (CFG_RD_I && ADDR_I == 8'h46 |=> RDATA_O == 32'h00000000)
        else $error("bridge extensions byte not zero");
    a_rdata_holds: assert property (!(IO_RD_I || CFG_RD_I || SW_RESET_I) |=> $stable(RDATA_O))
        else $error("read data changed without read");
    a_ptr_readback: assert property (ptr_wr_rd |=> RDATA_O == ($past(WDATA_I, 2) & 32'h000000FF))
        else $error("pointer readback wrong");
    a_int_has_cause: assert property ($fell(INT_N_O) |-> $past(FRAME_MISSED_I || IO_WR_I || BUS_REQ_I))
        else $error("interrupt without cause");
    c_ptr_b2b: cover property (ptr_wr_rd);
    c_int_fall: cover property ($fell(INT_N_O));
    c_missed: cover property (FRAME_MISSED_I && !STOP_O);
endmodule
bind irae_top irae_asserts irae_asserts_inst (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .SW_RESET_I(SW_RESET_I),
    .DOUBLEWORD_IO_MODE_I(DOUBLEWORD_IO_MODE_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I), .CFG_RD_I(CFG_RD_I),
    .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .ACK_O(ACK_O), .FRAME_MISSED_I(FRAME_MISSED_I),
    .BUS_REQ_I(BUS_REQ_I), .REQ_N_O(REQ_N_O), .INT_N_O(INT_N_O), .STOP_O(STOP_O));
`default_nettype wire

// file: test/irae_arbiter_model.sv
`timescale 1ns/10ps
`default_nettype none
module irae_arbiter_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_n_i,
    input wire logic stall_i,
    output logic gnt_n_o
);
    logic [1:0] wait_cnt;
    // Grant three cycles after a request, never while stalled
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_cnt <= 2'h0;
            gnt_n_o <= 1'b1;
        end else if (req_n_i || stall_i) begin
            wait_cnt <= 2'h0;
            gnt_n_o <= 1'b1;
        end else if (wait_cnt == 2'h2) begin
            gnt_n_o <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: test/test_indirect_register_access_and_error_flags.sv
`timescale 1ns/10ps
`default_nettype none
module test_indirect_register_access_and_error_flags;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sw_rst = 1'b0, dword = 1'b0, rd = 1'b0, wr = 1'b0, cfg = 1'b0, ee_load = 1'b0;
    logic half = 1'b0, mii = 1'b0, tbt = 1'b0, tx_end = 1'b0, bit_tick = 1'b0, col = 1'b0;
    logic missed = 1'b0, bus_req = 1'b0, stall = 1'b0;
    logic [7:0] addr = 8'h00, ee_data = 8'h00;
    logic [31:0] wdata = 32'h0, q;
    logic [31:0] rdata;
    logic ack, gnt_n, req_n, int_n, stop;
    int failures = 0;
    int total_checks = 0;
    always #25 clk = ~clk;
    irae_top irae_top_inst (.CLK_SYS_I(clk), .RSTN_I(rstn), .SW_RESET_I(sw_rst), .DOUBLEWORD_IO_MODE_I(dword),
        .IO_RD_I(rd),
        .IO_WR_I(wr), .CFG_RD_I(cfg), .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .ACK_O(ack),
        .EE_LOAD_I(ee_load), .EE_PM_DATA_I(ee_data), .HALF_DUPLEX_I(half), .MII_SEL_I(mii), .PHY_10BT_I(tbt),
        .TX_END_I(tx_end), .BIT_TICK_I(bit_tick), .COL_PIN_I(col), .FRAME_MISSED_I(missed),
        .BUS_REQ_I(bus_req), .GNT_N_PIN_I(gnt_n), .REQ_N_O(req_n), .INT_N_O(int_n), .STOP_O(stop));
    irae_arbiter_model irae_arbiter_model_inst (.clk_i(clk), .rstn_i(rstn), .req_n_i(req_n), .stall_i(stall),
        .gnt_n_o(gnt_n));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic r, input logic w, input logic c, input logic [7:0] a, input logic [31:0] d);
        rd = r;
        wr = w;
        cfg = c;
        addr = a;
        wdata = d;
        tick();
        chk(32'(ack), 32'h1);
        q = rdata;
    endtask
    task automatic idle();
        rd = 1'b0;
        wr = 1'b0;
        cfg = 1'b0;
        tick();
    endtask
    task automatic wr_io(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, 1'b1, 1'b0, a, d);
        idle();
    endtask
    task automatic rd_io(input logic [7:0] a);
        acc(1'b1, 1'b0, 1'b0, a, 32'h0);
        idle();
    endtask
    // Only defined indexes are written
    task automatic csr_wr(input logic [7:0] i, input logic [31:0] d);
        wr_io(dword ? 8'h14 : 8'h12, {24'h0, i});
        wr_io(8'h10, d);
    endtask
    task automatic csr_rd(input logic [7:0] i);
        wr_io(dword ? 8'h14 : 8'h12, {24'h0, i});
        rd_io(8'h10);
    endtask
    task automatic main_chk(input logic [31:0] e);
        csr_rd(8'h00);
        chk(q & 32'h0000F844, e);
    endtask
    task automatic t_reset();
        rd_io(8'h12);
        chk(q, 32'h0);
        acc(1'b0, 1'b0, 1'b1, 8'h46, 32'h0);
        idle();
        chk(q, 32'h0);
        main_chk(32'h4);
        chk(32'(int_n), 32'h1);
    endtask
    task automatic t_pm();
        ee_data = 8'hA5;
        ee_load = 1'b1;
        tick();
        ee_load = 1'b0;
        acc(1'b0, 1'b0, 1'b1, 8'h47, 32'h0);
        idle();
        chk(q, 32'hA5);
        wr_io(8'h12, 32'h25);
        rd_io(8'h16);
        chk(q & 32'hFF, 32'hA5);
        wr_io(8'h12, 32'h2C);
        rd_io(8'h16);
        chk(q & 32'hFF, 32'hA5);
        dword = 1'b1;
        tick();
        wr_io(8'h14, 32'h25);
        rd_io(8'h1C);
        chk(q & 32'hFF, 32'hA5);
        wr_io(8'h14, 32'h3);
        wr_io(8'h10, 32'h1800);
        rd_io(8'h14);
        chk(q, 32'h3);
        rd_io(8'h10);
        chk(q & 32'h1800, 32'h1800);
        wr_io(8'h10, 32'h0);
        dword = 1'b0;
        tick();
    endtask
    task automatic t_ptr();
        acc(1'b0, 1'b1, 1'b0, 8'h12, 32'h70);
        acc(1'b1, 1'b0, 1'b0, 8'h12, 32'h0);
        idle();
        chk(q, 32'h70);
        rd_io(8'h10);
        chk(q, 32'h0);
        rd_io(8'h30);
        chk(q, 32'h0);
        sw_rst = 1'b1;
        tick();
        sw_rst = 1'b0;
        rd_io(8'h12);
        chk(q, 32'h0);
        chk(32'(stop), 32'h1);
    endtask
    task automatic pulse_miss();
        missed = 1'b1;
        tick();
        missed = 1'b0;
        tick();
    endtask
    task automatic t_miss();
        csr_wr(8'h00, 32'h42);
        pulse_miss();
        main_chk(32'h9040);
        chk(32'(int_n), 32'h0);
        csr_rd(8'h70);
        chk(q & 32'hFFFF, 32'h1);
        csr_wr(8'h03, 32'h1000);
        chk(32'(int_n), 32'h1);
        csr_wr(8'h03, 32'h0);
        csr_wr(8'h00, 32'hC002);
        main_chk(32'h9000);
        chk(32'(int_n), 32'h1);
        csr_wr(8'h00, 32'h1042);
        main_chk(32'h0040);
        pulse_miss();
        csr_wr(8'h00, 32'h4);
        main_chk(32'h4);
        csr_wr(8'h00, 32'h42);
    endtask
    task automatic col_run(input logic h, input logic m, input logic t, input int hit, input logic exp);
        half = h;
        mii = m;
        tbt = t;
        tx_end = 1'b1;
        tick();
        tx_end = 1'b0;
        for (int i = 1; i <= 20; i++) begin
            col = (i == hit);
            if (i == 20) begin
                main_chk(32'h0040);
            end
            bit_tick = 1'b1;
            tick();
            bit_tick = 1'b0;
            tick(3);
        end
        col = 1'b0;
        main_chk(exp ? 32'hA040 : 32'h0040);
        chk(32'(int_n), 32'h1);
        csr_wr(8'h00, 32'h2042);
        main_chk(32'h0040);
    endtask
    task automatic t_col();
        col_run(1'b1, 1'b0, 1'b0, 0, 1'b1);
        col_run(1'b0, 1'b0, 1'b0, 0, 1'b0);
        col_run(1'b1, 1'b1, 1'b0, 0, 1'b0);
        col_run(1'b1, 1'b1, 1'b1, 0, 1'b1);
        col_run(1'b1, 1'b0, 1'b0, 5, 1'b0);
        half = 1'b0;
    endtask
    task automatic t_bus();
        csr_wr(8'h64, 32'h14);
        stall = 1'b1;
        bus_req = 1'b1;
        tick();
        chk(32'(req_n), 32'h0);
        main_chk(32'h0040);
        tick(60);
        main_chk(32'h8840);
        chk(32'(int_n), 32'h0);
        csr_wr(8'h03, 32'h800);
        chk(32'(int_n), 32'h1);
        csr_wr(8'h03, 32'h0);
        bus_req = 1'b0;
        stall = 1'b0;
        csr_wr(8'h00, 32'h42);
        main_chk(32'h8840);
        csr_wr(8'h00, 32'h842);
        main_chk(32'h0040);
        bus_req = 1'b1;
        tick(80);
        main_chk(32'h0040);
        bus_req = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        tick(10);
        rstn = 1'b1;
        tick();
        t_reset();
        t_pm();
        t_ptr();
        t_miss();
        t_col();
        t_bus();
        report_and_stop();
    end
    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
